/* dv/pio_pins_model.sv */
/*
 Pin-side partner: resolves the dedicated pins and data-bus byte lines.
 Assumes the bench supplies the outside levels on ext_lines.
*/
`timescale 1ns/1ns
module pio_pins_model (
	input logic [15:0] gpio_out,
	input logic [15:0] gpio_oe,
	input logic [15:0] dbus_out,
	input logic [15:0] dbus_oe,
	input logic [31:0] ext_lines,
	output logic [15:0] gpio_in,
	output logic [15:0] dbus_in
);
	// a driven line shows the block's own level
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			gpio_in[i] = gpio_oe[i] ? gpio_out[i] : ext_lines[i];
			dbus_in[i] = dbus_oe[i] ? dbus_out[i] : ext_lines[16+i];
		end
	end
endmodule

/* dv/pio_top_test.sv */
/*
 Self-checking bench for the parallel I/O port.
 Assumes zero or more wait states on APB and the pin model on the far side.
*/
`timescale 1ns/1ns
module pio_top_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic bus8_mode, sdram_en, irq, en, edg, pol;
	logic [31:0] paddr, pwdata, prdata, ext, r, v, x, dm, cfg;
	logic [15:0] gpio_in, gpio_out, gpio_oe, dbus_in, dbus_out, dbus_oe;
	logic [7:0] chan_irq;
	logic [4:0] src;
	logic [64:0] note;
	logic [64:0] q[$];
	int err_count, num_checks, cnt, m, n;

	pio_top pio_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.dbus_in(dbus_in), .dbus_out(dbus_out), .dbus_oe(dbus_oe),
		.bus8_mode(bus8_mode), .sdram_en(sdram_en), .chan_irq(chan_irq),
		.irq(irq));
	pio_pins_model pio_pins_model_i (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.dbus_out(dbus_out), .dbus_oe(dbus_oe), .ext_lines(ext),
		.gpio_in(gpio_in), .dbus_in(dbus_in));

	always #10 pclk = ~pclk;

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task summarize();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// note holds error flag, compare mask, expected data
	task automatic xfer(logic w, logic [31:0] a, d, logic [64:0] n);
		int k;
		k = 0;
		q.push_back(n);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			chk("pready", 1, 0);
			summarize();
		end
	endtask

	task automatic wr(logic [31:0] a, d);
		xfer(1'b1, a, d, '0);
	endtask

	task automatic rd(logic [31:0] a, e, mk);
		xfer(1'b0, a, '0, {1'b0, mk, e});
	endtask

	// result side: oldest note against each completed access
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			note = q.pop_front();
			chk("pslverr", {31'h0, note[64]}, {31'h0, pslverr});
			if (!pwrite)
				chk("prdata", note[31:0] & note[63:32], prdata & note[63:32]);
		end
	end

	initial begin
		pclk = 0;
		presetn = 0;
		{psel, penable, pwrite} = '0;
		paddr = '0;
		pwdata = '0;
		bus8_mode = 1;
		sdram_en = 0;
		ext = '0;
		void'($urandom(3));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd(pio_pkg::PIO_ADDR_VALUE + 32'(4 * i), '0, '1);
		xfer(1'b1, 32'h800000B8, '1, {1'b1, 64'h0});
		xfer(1'b0, 32'h800000B8, '0, {1'b1, 32'hFFFFFFFF, 32'h0});
		$display("test reset and unmapped done");
		r = $urandom;
		v = $urandom;
		x = $urandom;
		ext <= x;
		wr(pio_pkg::PIO_ADDR_DIR, r);
		rd(pio_pkg::PIO_ADDR_DIR, r & 32'h3FFFF, '1);
		@(negedge pclk);
		chk("gpio_oe", {16'h0, r[15:0]}, {16'h0, gpio_oe});
		chk("dbus_oe", {16'h0, {8{r[17]}}, {8{r[16]}}}, {16'h0, dbus_oe});
		wr(pio_pkg::PIO_ADDR_VALUE, v);
		repeat (3) @(posedge pclk);
		chk("gpio_out", {16'h0, v[15:0]}, {16'h0, gpio_out});
		chk("dbus_out", {16'h0, v[31:16]}, {16'h0, dbus_out});
		dm = {{8{r[17]}}, {8{r[16]}}, r[15:0]};
		rd(pio_pkg::PIO_ADDR_VALUE, (v & dm) | (x & ~dm), '1);
		sdram_en <= 1'b1;
		repeat (3) @(posedge pclk);
		rd(pio_pkg::PIO_ADDR_VALUE, (v & dm | x & ~dm) & 32'hFFFF, '1);
		chk("dbus_oe", 0, {16'h0, dbus_oe});
		// upper value bits must ignore writes while the bus is not ours
		wr(pio_pkg::PIO_ADDR_VALUE, ~v);
		@(negedge pclk);
		chk("gpio_out", {16'h0, ~v[15:0]}, {16'h0, gpio_out});
		chk("dbus_out", {16'h0, v[31:16]}, {16'h0, dbus_out});
		@(posedge pclk);
		{bus8_mode, sdram_en} <= 2'b00;
		@(negedge pclk);
		chk("dbus_oe", 0, {16'h0, dbus_oe});
		@(posedge pclk);
		bus8_mode <= 1'b1;
		wr(pio_pkg::PIO_ADDR_DIR, '0);
		$display("test direction and value done");
		// ten passes so channel 0 also runs in edge mode
		for (int i = 0; i < 10; i++) begin
			n = i % 8;
			m = i % 5;
			{edg, pol} = m[1:0];
			en = m < 4;
			src = 5'($urandom_range(31, 0));
			ext <= {31'h0, !pol} << src;
			cfg = {24'h0, en, edg, pol, src} << (8 * (n % 4));
			wr(pio_pkg::PIO_ADDR_CFG_LO, n < 4 ? cfg : '0);
			wr(pio_pkg::PIO_ADDR_CFG_HI, n < 4 ? '0 : cfg);
			repeat (6) @(posedge pclk);
			rd(pio_pkg::PIO_ADDR_STS, '0, '0);
			ext[src] <= pol;
			cnt = 0;
			repeat (6) @(negedge pclk) cnt += (chan_irq[n] !== 1'b0);
			chk("pulse count", en ? (edg ? 1 : 4) : 0, cnt);
			chk("irq masked", 0, {31'h0, irq});
			wr(pio_pkg::PIO_ADDR_MSK, 32'(1) << n);
			@(negedge pclk);
			chk("irq", {31'h0, en}, {31'h0, irq});
			rd(pio_pkg::PIO_ADDR_STS, 32'(en) << n, 32'hFF);
			rd(pio_pkg::PIO_ADDR_STS, 32'(en && !edg) << n, 32'hFF);
			wr(pio_pkg::PIO_ADDR_MSK, '0);
			ext[src] <= !pol;
			repeat (6) @(posedge pclk);
			rd(pio_pkg::PIO_ADDR_STS, '0, '0);
			$display("test channel %0d done", n);
		end
		repeat (3) @(posedge pclk);
		summarize();
	end
endmodule

/* rtl/pio_chan.sv */
/*
 One port interrupt channel: picks a port line, then detects a level or
 an edge of the chosen polarity and raises its request.
 Assumes the port lines are already synchronised to pclk.
*/
`timescale 1ns/1ns
module pio_chan (
	input logic pclk,
	input logic presetn,
	input pio_pkg::pio_chan_cfg_t cfg,
	input logic [pio_pkg::PIO_DATA_W-1:0] lines,
	output logic req
);

	pio_pkg::pio_chan_state_t q;
	pio_pkg::pio_chan_state_t d;
	logic sel;
	logic active;
	logic was_active;

	assign sel = lines[cfg.source_line];
	assign active = (sel == cfg.polarity);
	assign was_active = (q.prev == cfg.polarity);

	always_comb begin
		d = q;
		d.prev = sel;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= pio_pkg::PIO_CHAN_RST;
		end else begin
			q <= d;
		end
	end

	// edge mode gives a single cycle on the chosen transition
	always_comb begin
		if (!cfg.unmask) begin
			req = 1'b0;
		end else if (cfg.edge_sel) begin
			req = active & ~was_active;
		end else begin
			req = active;
		end
	end

endmodule

/* rtl/pio_pkg.sv */
/*
 Package for the parallel I/O port with configurable port interrupts:
 register addresses, widths, bit positions, reset values and the packed
 types shared by the top module and the channel detector.
 Assumes a 32-bit APB register bus with full byte addresses.
*/
package pio_pkg;

	localparam int PIO_DATA_W = 32;
	localparam int PIO_PIN_W = 16;
	localparam int PIO_DBUS_W = 16;
	localparam int PIO_NUM_CHAN = 8;
	localparam int PIO_CHAN_W = 8;
	localparam int PIO_SEL_W = 5;
	localparam int PIO_DIR_W = 18;
	localparam int PIO_DIR_LOW_BIT = 16;
	localparam int PIO_DIR_HIGH_BIT = 17;
	localparam int PIO_BYTE_W = 8;
	localparam int PIO_CFG_W = 64;

	// register byte addresses
	localparam logic [31:0] PIO_ADDR_VALUE = 32'h800000A0;
	localparam logic [31:0] PIO_ADDR_DIR = 32'h800000A4;
	localparam logic [31:0] PIO_ADDR_CFG_LO = 32'h800000A8;
	localparam logic [31:0] PIO_ADDR_CFG_HI = 32'h800000AC;
	localparam logic [31:0] PIO_ADDR_STS = 32'h800000B0;
	localparam logic [31:0] PIO_ADDR_MSK = 32'h800000B4;

	// which port lines exist in each bus mode
	localparam logic [31:0] PIO_PIN_LINES = 32'h0000FFFF;
	localparam logic [31:0] PIO_ALL_LINES = 32'hFFFFFFFF;

	typedef struct packed {
		logic unmask;
		logic edge_sel;
		logic polarity;
		logic [PIO_SEL_W-1:0] source_line;
	} pio_chan_cfg_t;

	typedef struct packed {
		logic prev;
	} pio_chan_state_t;

	typedef struct packed {
		logic [PIO_DATA_W-1:0] out_val;
		logic [PIO_DIR_W-1:0] dir;
		logic [PIO_DATA_W-1:0] cfg_lo;
		logic [PIO_DATA_W-1:0] cfg_hi;
		logic [PIO_NUM_CHAN-1:0] sts;
		logic [PIO_NUM_CHAN-1:0] msk;
		logic [PIO_DATA_W-1:0] sync1;
		logic [PIO_DATA_W-1:0] sync2;
		logic [PIO_DATA_W-1:0] rdata;
	} pio_state_t;

	localparam pio_state_t PIO_STATE_RST = '0;
	localparam pio_chan_state_t PIO_CHAN_RST = '0;

endpackage

/* rtl/pio_top.sv */
/*
 Parallel I/O port top: APB register slave, port value and direction,
 sixteen dedicated pins, two data-bus byte lanes, eight port interrupt
 channels, sticky interrupt status with mask and one interrupt output.
 Assumes a memory controller drives bus8_mode and sdram_en, pins are
 synchronous enough for a two-flop synchroniser, and an interrupt
 controller takes chan_irq.
*/
// Local design decision: register access over APB.
`timescale 1ns/1ns
module pio_top (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [31:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input logic [pio_pkg::PIO_PIN_W-1:0] gpio_in,
	output logic [pio_pkg::PIO_PIN_W-1:0] gpio_out,
	output logic [pio_pkg::PIO_PIN_W-1:0] gpio_oe,
	input logic [pio_pkg::PIO_DBUS_W-1:0] dbus_in,
	output logic [pio_pkg::PIO_DBUS_W-1:0] dbus_out,
	output logic [pio_pkg::PIO_DBUS_W-1:0] dbus_oe,
	input logic bus8_mode,
	input logic sdram_en,
	output logic [pio_pkg::PIO_NUM_CHAN-1:0] chan_irq,
	output logic irq
);

	pio_pkg::pio_state_t q;
	pio_pkg::pio_state_t d;
	pio_pkg::pio_chan_cfg_t [pio_pkg::PIO_NUM_CHAN-1:0] cfg;
	logic [pio_pkg::PIO_CFG_W-1:0] cfg_all;
	logic [pio_pkg::PIO_NUM_CHAN-1:0] req;
	logic [pio_pkg::PIO_NUM_CHAN-1:0] unmask_vec;
	logic [pio_pkg::PIO_NUM_CHAN-1:0] sts_clr;
	logic [31:0] avail;
	logic [31:0] lines_eff;
	logic [31:0] rd_mux;
	logic bus_ok;
	logic setup;
	logic acc;
	logic wr;
	logic hit;

	// byte lanes exist only in full 8-bit bus mode with SDRAM off
	assign bus_ok = bus8_mode & ~sdram_en;
	assign avail = bus_ok ? pio_pkg::PIO_ALL_LINES :
		pio_pkg::PIO_PIN_LINES;
	assign lines_eff = q.sync2 & avail;
	assign cfg_all = {q.cfg_hi, q.cfg_lo};

	assign setup = psel & ~penable;
	assign acc = psel & penable;
	assign wr = acc & pwrite;

	always_comb begin
		hit = 1'b1;
		rd_mux = '0;
		case (paddr)
			pio_pkg::PIO_ADDR_VALUE: begin
				rd_mux = lines_eff;
			end
			pio_pkg::PIO_ADDR_DIR: begin
				rd_mux = 32'(q.dir);
			end
			pio_pkg::PIO_ADDR_CFG_LO: begin
				rd_mux = q.cfg_lo;
			end
			pio_pkg::PIO_ADDR_CFG_HI: begin
				rd_mux = q.cfg_hi;
			end
			pio_pkg::PIO_ADDR_STS: begin
				rd_mux = 32'(q.sts);
			end
			pio_pkg::PIO_ADDR_MSK: begin
				rd_mux = 32'(q.msk);
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	// a status read clears only what it returned, so new events survive
	always_comb begin
		sts_clr = '0;
		if (acc && !pwrite && paddr == pio_pkg::PIO_ADDR_STS) begin
			sts_clr = q.rdata[pio_pkg::PIO_NUM_CHAN-1:0];
		end
	end

	always_comb begin
		d = q;
		d.sync1 = {dbus_in, gpio_in};
		d.sync2 = q.sync1;
		if (setup && !pwrite) begin
			d.rdata = rd_mux;
		end
		if (wr) begin
			case (paddr)
				pio_pkg::PIO_ADDR_VALUE: begin
					d.out_val[pio_pkg::PIO_PIN_W-1:0] =
						pwdata[pio_pkg::PIO_PIN_W-1:0];
					if (bus_ok) begin
						d.out_val[31:pio_pkg::PIO_PIN_W] =
							pwdata[31:pio_pkg::PIO_PIN_W];
					end
				end
				pio_pkg::PIO_ADDR_DIR: begin
					d.dir = pwdata[pio_pkg::PIO_DIR_W-1:0];
				end
				pio_pkg::PIO_ADDR_CFG_LO: begin
					d.cfg_lo = pwdata;
				end
				pio_pkg::PIO_ADDR_CFG_HI: begin
					d.cfg_hi = pwdata;
				end
				pio_pkg::PIO_ADDR_MSK: begin
					d.msk = pwdata[pio_pkg::PIO_NUM_CHAN-1:0];
				end
				default: begin
				end
			endcase
		end
		d.sts = (q.sts & ~sts_clr) | req;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= pio_pkg::PIO_STATE_RST;
		end else begin
			q <= d;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < pio_pkg::PIO_NUM_CHAN; gi++) begin : g_chan
			assign cfg[gi] = pio_pkg::pio_chan_cfg_t'(
				cfg_all[gi*pio_pkg::PIO_CHAN_W +: pio_pkg::PIO_CHAN_W]);
			assign unmask_vec[gi] = cfg[gi].unmask;
			pio_chan u_chan (
				.pclk(pclk),
				.presetn(presetn),
				.cfg(cfg[gi]),
				.lines(lines_eff),
				.req(req[gi])
			);
		end
	endgenerate

	assign prdata = q.rdata;
	assign pready = 1'b1;
	assign pslverr = acc & ~hit;
	assign gpio_out = q.out_val[pio_pkg::PIO_PIN_W-1:0];
	assign gpio_oe = q.dir[pio_pkg::PIO_PIN_W-1:0];
	assign dbus_out = q.out_val[31:pio_pkg::PIO_PIN_W];
	// byte lanes float unless the memory bus allows port use
	assign dbus_oe = bus_ok ?
		{{pio_pkg::PIO_BYTE_W{q.dir[pio_pkg::PIO_DIR_HIGH_BIT]}},
		{pio_pkg::PIO_BYTE_W{q.dir[pio_pkg::PIO_DIR_LOW_BIT]}}} :
		'0;
	assign chan_irq = req;
	assign irq = |(q.sts & q.msk);

	// helpers for the checks below
	logic w_dir_hi;
	logic w_dir_lo;
	logic [pio_pkg::PIO_PIN_W-1:0] w_pins;
	logic [pio_pkg::PIO_CHAN_W-1:0] w_byte0;
	logic [pio_pkg::PIO_CHAN_W-1:0] w_byte3;
	logic sel0;
	logic [pio_pkg::PIO_PIN_W-1:0] sync_pins;

	assign w_dir_hi = pwdata[pio_pkg::PIO_DIR_HIGH_BIT];
	assign w_dir_lo = pwdata[pio_pkg::PIO_DIR_LOW_BIT];
	assign w_pins = pwdata[pio_pkg::PIO_PIN_W-1:0];
	assign w_byte0 = pwdata[pio_pkg::PIO_CHAN_W-1:0];
	assign w_byte3 = pwdata[31:24];
	assign sel0 = lines_eff[cfg[0].source_line];
	assign sync_pins = q.sync2[pio_pkg::PIO_PIN_W-1:0];

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_wr(logic [31:0] a);
		psel && penable && pwrite && paddr == a;
	endsequence

	sequence s_rd_setup(logic [31:0] a);
		psel && !penable && !pwrite && paddr == a;
	endsequence

	sequence s_edge0;
		cfg[0].unmask && cfg[0].edge_sel && sel0 != cfg[0].polarity
		##1 sel0 == cfg[0].polarity && $stable(cfg[0]);
	endsequence

	property p_value_pins;
		s_wr(pio_pkg::PIO_ADDR_VALUE) |=> gpio_out == $past(w_pins);
	endproperty
	a_value_pins: assert property (p_value_pins)
		else $error("pin output differs from written port value");

	property p_value_read;
		s_rd_setup(pio_pkg::PIO_ADDR_VALUE) |=> prdata == $past(lines_eff);
	endproperty
	a_value_read: assert property (p_value_read)
		else $error("port value read does not show port lines");

	property p_byte_gate;
		!bus_ok |-> dbus_oe == '0 && lines_eff[31:16] == '0;
	endproperty
	a_byte_gate: assert property (p_byte_gate)
		else $error("bus byte lines used outside 8-bit mode");

	property p_dir_high;
		s_wr(pio_pkg::PIO_ADDR_DIR) ##1 bus_ok |->
			dbus_oe[15:8] == {8{$past(w_dir_hi)}};
	endproperty
	a_dir_high: assert property (p_dir_high)
		else $error("upper byte direction not applied");

	property p_dir_low;
		s_wr(pio_pkg::PIO_ADDR_DIR) ##1 bus_ok |->
			dbus_oe[7:0] == {8{$past(w_dir_lo)}};
	endproperty
	a_dir_low: assert property (p_dir_low)
		else $error("lower byte direction not applied");

	property p_dir_pins;
		s_wr(pio_pkg::PIO_ADDR_DIR) |=> gpio_oe == $past(w_pins);
	endproperty
	a_dir_pins: assert property (p_dir_pins)
		else $error("pin direction not applied");

	property p_unmask;
		(chan_irq & ~unmask_vec) == '0;
	endproperty
	a_unmask: assert property (p_unmask)
		else $error("masked channel raised a request");

	property p_level;
		cfg[0].unmask && !cfg[0].edge_sel && sel0 == cfg[0].polarity
			|-> chan_irq[0];
	endproperty
	a_level: assert property (p_level)
		else $error("level channel missed an active level");

	property p_edge_pulse;
		s_edge0 |-> chan_irq[0] ##1 !chan_irq[0] || !$stable(cfg[0]);
	endproperty
	a_edge_pulse: assert property (p_edge_pulse)
		else $error("edge channel did not give a one-cycle pulse");

	property p_cfg_lo;
		s_wr(pio_pkg::PIO_ADDR_CFG_LO) |=> cfg[0] == $past(w_byte0);
	endproperty
	a_cfg_lo: assert property (p_cfg_lo)
		else $error("channel 0 not in low byte of low config");

	property p_cfg_hi;
		s_wr(pio_pkg::PIO_ADDR_CFG_HI) |=> cfg[7] == $past(w_byte3);
	endproperty
	a_cfg_hi: assert property (p_cfg_hi)
		else $error("channel 7 not in top byte of high config");

	property p_reset;
		$rose(presetn) |-> gpio_oe == '0 && dbus_oe == '0 &&
			chan_irq == '0;
	endproperty
	a_reset: assert property (p_reset)
		else $error("port not idle after reset");

	property p_sync;
		$past(presetn, 2) |-> sync_pins == $past(gpio_in, 2);
	endproperty
	a_sync: assert property (p_sync)
		else $error("pin synchroniser is not two cycles");

	property p_sticky;
		chan_irq[0] |=> q.sts[0];
	endproperty
	a_sticky: assert property (p_sticky)
		else $error("channel request lost from status");

endmodule
